// ==== mfa_arith_unit.sv ====
// Fixed-point arithmetic unit with float compare, driven over AXI4-Lite
// Notes on behaviour
// - Add writes two's-complement sum to S
// - Transfer: page load, else increment bits 0-11
// - 240 ns basic, 380 ns on fall-through
// - Add sets G, L, V, C from sum
// - Add-plus-one forces carry-in of one
// - Subtract writes first minus second to S
// - Subtract flags; C carries the borrow
// - Subtract-minus-one takes one more off
// - Multiply: high to S, low to A, flags cleared
// - Divide even/odd dividend, quotient A, remainder S
// - Remainder takes the dividend's sign
// - Quotient overflow aborts, sets V, A kept
// - Decode class, format, op, B, C, page
// - Float: sign, excess-64 exponent, hex fraction
// - Module 3 routes register references to float bank
// - Float bank holds sixteen 32-bit registers
// - Float compare changes flags only
// - Compare: equal clear, less C+L, greater G
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "mfa_defines.svh"
module mfa_arith_unit (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   localparam logic [6:0] CycBasic = 7'(`MFA_CYC(`MFA_T_BASIC_NS));
   localparam logic [6:0] CycFall  = 7'(`MFA_CYC(`MFA_T_FALL_NS));
   localparam logic [6:0] CycMul   = 7'(`MFA_CYC(`MFA_T_MUL_NS));
   localparam logic [6:0] CycDiv   = 7'(`MFA_CYC(`MFA_T_DIV_NS));
   mfa_pkg::mfa_regs_type r_r;      // All state
   mfa_pkg::mfa_regs_type r_nxt;    // Next value of all state
   // Merge written bytes into an old word
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction
   // Register code to bank index, user pointers resolved
   function automatic logic [3:0] regIndex(input logic [4:0] code,
                                           input logic [7:0] uptr);
      if (code == `MFA_REG_DEST_PTR) begin
         return uptr[3:0];
      end else if (code == `MFA_REG_SRC_PTR) begin
         return uptr[7:4];
      end
      return code[3:0];
   endfunction
   // Decoded fields of the latched micro-instruction
   logic [2:0]         opClass;   // Class code
   logic [1:0]         opFmt;     // Control, transfer or immediate
   logic [3:0]         opCode;    // Operation code
   logic [3:0]         sIdx;      // Destination index
   logic [3:0]         aIdx;      // First operand index
   logic               useFlt;    // Float bank selected
   logic [31:0]        aVal;      // First operand
   logic [31:0]        bVal;      // Second operand
   logic [31:0]        sVal;      // Destination old content (dividend high)
   logic [32:0]        sum33;     // Adder with carry out
   logic               isSub;     // Subtract family
   logic               cIn;       // Adder carry in
   logic [31:0]        bAdd;      // Adder second input
   logic signed [63:0] prod;      // Signed product
   logic signed [63:0] dvd;       // Dividend pair
   logic signed [63:0] dvs;       // Sign-extended divisor
   logic signed [63:0] quo;       // Quotient
   logic signed [63:0] rem;       // Remainder
   logic               divOvf;    // Divide fault
   logic               carryNew;  // New C flag of add family
   logic [6:0]         target;    // Cycles for this operation
   logic               fallThru;  // Transfer falls through
   logic               isAddFam;  // Add or subtract family
   logic [31:0]        fa;        // Float key of first operand
   logic [31:0]        fb;        // Float key of second operand
   // Operand fetch and arithmetic, all from the latched word
   always_comb begin
      opClass = r_r.instr[`MFA_F_CLASS];
      opFmt   = r_r.instr[`MFA_F_FMT];
      opCode  = r_r.instr[`MFA_F_OP];
      useFlt  = (r_r.modSel == `MFA_FLT_MODULE);
      sIdx    = regIndex(r_r.instr[`MFA_F_S], r_r.uptr);
      aIdx    = regIndex(r_r.instr[`MFA_F_A], r_r.uptr);
      aVal    = useFlt ? r_r.fpr[aIdx] : r_r.gpr[aIdx];
      sVal    = useFlt ? r_r.fpr[sIdx] : r_r.gpr[sIdx];
      // Immediate data is zero-extended into the second operand
      if (opFmt == `MFA_FMT_IMM) begin
         bVal = {20'h00000, r_r.instr[`MFA_F_DATA]};
      end else begin
         bVal = useFlt ? r_r.fpr[regIndex(r_r.instr[`MFA_F_B], r_r.uptr)]
                       : r_r.gpr[regIndex(r_r.instr[`MFA_F_B], r_r.uptr)];
      end
      // Subtract runs as A + ~B + 1; the decrement form drops the one
      isSub = (opCode == `MFA_OP_SUB) || (opCode == `MFA_OP_SUBDEC);
      cIn   = (opCode == `MFA_OP_ADDINC) || (opCode == `MFA_OP_SUB);
      bAdd  = isSub ? ~bVal : bVal;
      sum33 = {1'b0, aVal} + {1'b0, bAdd} + {32'h00000000, cIn};
      carryNew = isSub ? ~sum33[32] : sum33[32];
      prod  = $signed(aVal) * $signed(bVal);
      // Dividend is the even/odd pair; a zero divisor is a fault
      dvd = $signed({sVal, aVal});
      dvs = $signed({{32{bVal[31]}}, bVal});
      quo = (dvs == 64'sh0000000000000000) ? 64'sh0000000000000000 : dvd / dvs;
      rem = (dvs == 64'sh0000000000000000) ? 64'sh0000000000000000 : dvd % dvs;
      divOvf = (dvs == 64'sh0000000000000000) || (quo > 64'sh000000007FFFFFFF)
             || (quo < $signed(64'hFFFFFFFF80000000));
      // Float key: fold the sign so exponent and hex fraction order plainly
      fa = aVal[31] ? ~aVal : (aVal ^ 32'h80000000);
      fb = bVal[31] ? ~bVal : (bVal ^ 32'h80000000);
      isAddFam = (opClass == `MFA_CLASS_FIX) && (opCode[3:2] == 2'h0);
      fallThru = isAddFam && (opFmt == `MFA_FMT_XFER)
               && r_r.instr[`MFA_F_C] && carryNew;
      // Execution length depends on the operation and the branch outcome
      if ((opClass == `MFA_CLASS_FIX) && (opCode == `MFA_OP_MUL)) begin
         target = CycMul;
      end else if ((opClass == `MFA_CLASS_FIX) && (opCode == `MFA_OP_DIV)) begin
         target = CycDiv;
      end else if (fallThru) begin
         target = CycFall;
      end else begin
         target = CycBasic;
      end
   end
   // Next-state logic: bus slave, issue, count and commit
   always_comb begin
      r_nxt = r_r;
      // Write address and data are taken independently
      if (awvalid && r_r.awready) begin
         r_nxt.awHeld  = 1'b1;
         r_nxt.awAddr  = awaddr;
         r_nxt.awready = 1'b0;
      end
      if (wvalid && r_r.wready) begin
         r_nxt.wHeld  = 1'b1;
         r_nxt.wData  = wdata;
         r_nxt.wStrb  = wstrb;
         r_nxt.wready = 1'b0;
      end
      if (r_r.bvalid && bready) begin
         r_nxt.bvalid = 1'b0;
      end
      // Both halves present: perform the write and answer
      if (r_r.awHeld && r_r.wHeld && !r_r.bvalid) begin
         r_nxt.awHeld  = 1'b0;
         r_nxt.wHeld   = 1'b0;
         r_nxt.awready = 1'b1;
         r_nxt.wready  = 1'b1;
         r_nxt.bvalid  = 1'b1;
         r_nxt.bresp   = `MFA_RESP_OKAY;
         if (r_r.awAddr[7:5] != 3'h0) begin
            r_nxt.bresp = `MFA_RESP_SLVERR;
         end else begin
            case (r_r.awAddr[4:2])
               `MFA_OFS_INSTR: begin
                  // Issue is ignored while an operation runs
                  if (r_r.phase == mfa_pkg::MFA_IDLE) begin
                     r_nxt.instr = mergeBytes(r_r.instr, r_r.wData, r_r.wStrb);
                     r_nxt.phase = mfa_pkg::MFA_EXEC;
                     r_nxt.cnt   = 7'h00;
                  end
               end
               `MFA_OFS_STATUS: begin
                  r_nxt.flags = r_r.wData[3:0];
               end
               `MFA_OFS_LOC: begin
                  r_nxt.loc = r_r.wData[15:0];
               end
               `MFA_OFS_MODSEL: begin
                  r_nxt.modSel = r_r.wData[3:0];
               end
               `MFA_OFS_REGIDX: begin
                  r_nxt.regIdx = r_r.wData[4:0];
               end
               `MFA_OFS_REGDATA: begin
                  // Blocked while busy so operands stay stable
                  if (r_r.phase == mfa_pkg::MFA_IDLE) begin
                     if (r_r.regIdx[4]) begin
                        r_nxt.fpr[r_r.regIdx[3:0]] = mergeBytes(
                           r_r.fpr[r_r.regIdx[3:0]], r_r.wData, r_r.wStrb);
                     end else begin
                        r_nxt.gpr[r_r.regIdx[3:0]] = mergeBytes(
                           r_r.gpr[r_r.regIdx[3:0]], r_r.wData, r_r.wStrb);
                     end
                  end
               end
               `MFA_OFS_UPTR: begin
                  r_nxt.uptr = r_r.wData[7:0];
               end
               default: begin
                  r_nxt.bresp = `MFA_RESP_SLVERR;
               end
            endcase
         end
      end
      // Read channel: one outstanding read, data registered
      if (r_r.rvalid && rready) begin
         r_nxt.rvalid  = 1'b0;
         r_nxt.arready = 1'b1;
      end
      if (arvalid && r_r.arready) begin
         r_nxt.arready = 1'b0;
         r_nxt.rvalid  = 1'b1;
         r_nxt.rresp   = `MFA_RESP_OKAY;
         r_nxt.rdata   = 32'h00000000;
         if (araddr[7:5] != 3'h0) begin
            r_nxt.rresp = `MFA_RESP_SLVERR;
         end else begin
            case (araddr[4:2])
               `MFA_OFS_INSTR:   r_nxt.rdata = r_r.instr;
               `MFA_OFS_STATUS:  r_nxt.rdata = {27'h0000000, r_r.phase, r_r.flags};
               `MFA_OFS_LOC:     r_nxt.rdata = {16'h0000, r_r.loc};
               `MFA_OFS_MODSEL:  r_nxt.rdata = {28'h0000000, r_r.modSel};
               `MFA_OFS_REGIDX:  r_nxt.rdata = {27'h0000000, r_r.regIdx};
               `MFA_OFS_REGDATA: r_nxt.rdata = r_r.regIdx[4] ? r_r.fpr[r_r.regIdx[3:0]]
                                                             : r_r.gpr[r_r.regIdx[3:0]];
               `MFA_OFS_UPTR:    r_nxt.rdata = {24'h000000, r_r.uptr};
               default:          r_nxt.rresp = `MFA_RESP_SLVERR;
            endcase
         end
      end
      // Execution: count to the operation's length, then commit once
      case (r_r.phase)
         mfa_pkg::MFA_IDLE: begin
            r_nxt.cnt = 7'h00;
         end
         mfa_pkg::MFA_EXEC: begin
            r_nxt.cnt = r_r.cnt + 7'h01;
            if (r_r.cnt == target - 7'h01) begin
               r_nxt.phase = mfa_pkg::MFA_IDLE;
               if (isAddFam) begin
                  // Add and subtract family write result and all flags
                  if (useFlt) begin
                     r_nxt.fpr[sIdx] = sum33[31:0];
                  end else begin
                     r_nxt.gpr[sIdx] = sum33[31:0];
                  end
                  r_nxt.flags[3] = carryNew;
                  r_nxt.flags[2] = (aVal[31] == bAdd[31])
                                 && (sum33[31] != aVal[31]);
                  r_nxt.flags[1] = !sum33[31] && (sum33[31:0] != 32'h00000000);
                  r_nxt.flags[0] = sum33[31];
                  if (opFmt == `MFA_FMT_XFER) begin
                     if (fallThru) begin
                        r_nxt.loc[11:0] = r_r.loc[11:0] + 12'h001;
                     end else begin
                        r_nxt.loc[5:0] = r_r.instr[`MFA_F_PAGE];
                     end
                  end
               end else if ((opClass == `MFA_CLASS_FIX) && (opCode == `MFA_OP_MUL)) begin
                  if (useFlt) begin
                     r_nxt.fpr[sIdx] = prod[63:32];
                     r_nxt.fpr[aIdx] = prod[31:0];
                  end else begin
                     r_nxt.gpr[sIdx] = prod[63:32];
                     r_nxt.gpr[aIdx] = prod[31:0];
                  end
                  r_nxt.flags = 4'h0;
                  if (opFmt == `MFA_FMT_XFER) begin
                     r_nxt.loc[5:0] = r_r.instr[`MFA_F_PAGE];
                  end
               end else if ((opClass == `MFA_CLASS_FIX) && (opCode == `MFA_OP_DIV)) begin
                  // On a fault both registers are left as they were
                  r_nxt.flags = divOvf ? 4'h4 : 4'h0;
                  if (!divOvf) begin
                     if (useFlt) begin
                        r_nxt.fpr[aIdx] = quo[31:0];
                        r_nxt.fpr[sIdx] = rem[31:0];
                     end else begin
                        r_nxt.gpr[aIdx] = quo[31:0];
                        r_nxt.gpr[sIdx] = rem[31:0];
                     end
                  end
                  if (opFmt == `MFA_FMT_XFER) begin
                     r_nxt.loc[5:0] = r_r.instr[`MFA_F_PAGE];
                  end
               end else if ((opClass == `MFA_CLASS_FLT) && (opCode == `MFA_OP_FCMP)) begin
                  // Nothing is written to the register banks
                  if (fa == fb) begin
                     r_nxt.flags = 4'h0;
                  end else if (fa < fb) begin
                     r_nxt.flags = 4'h9;
                  end else begin
                     r_nxt.flags = 4'h2;
                  end
               end
            end
         end
         default: begin
            r_nxt.phase = mfa_pkg::MFA_IDLE;
         end
      endcase
   end
   // State register; clock enable low freezes everything
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r         <= '0;
         r_r.awready <= 1'b1;
         r_r.wready  <= 1'b1;
         r_r.arready <= 1'b1;
      end else if (ce) begin
         r_r <= r_nxt;
      end
   end
   // Bus outputs straight from the state register
   assign awready = r_r.awready;
   assign wready  = r_r.wready;
   assign bvalid  = r_r.bvalid;
   assign bresp   = r_r.bresp;
   assign arready = r_r.arready;
   assign rvalid  = r_r.rvalid;
   assign rdata   = r_r.rdata;
   assign rresp   = r_r.rresp;
endmodule

// ==== mfa_defines.svh ====
// Constants for the fixed-point arithmetic unit: offsets, fields, codes and timing
`ifndef MFA_DEFINES_SVH
`define MFA_DEFINES_SVH
// Register word indices on the AXI4-Lite slave, decoded from byte address bits 4:2
`define MFA_OFS_INSTR   3'h0
`define MFA_OFS_STATUS  3'h1
`define MFA_OFS_LOC     3'h2
`define MFA_OFS_MODSEL  3'h3
`define MFA_OFS_REGIDX  3'h4
`define MFA_OFS_REGDATA 3'h5
`define MFA_OFS_UPTR    3'h6
`define MFA_RESP_OKAY   2'h0
`define MFA_RESP_SLVERR 2'h2
// Micro-instruction fields, bit 31 of the word is the MSB
`define MFA_F_CLASS     31:29
`define MFA_F_FMT       28:27
`define MFA_F_S         25:21
`define MFA_F_A         20:16
`define MFA_F_OP        15:12
`define MFA_F_B         11:7
`define MFA_F_C         6
`define MFA_F_PAGE      5:0
`define MFA_F_DATA      11:0
`define MFA_CLASS_FIX   3'h1
`define MFA_CLASS_FLT   3'h3
`define MFA_FMT_XFER    2'h0
`define MFA_FMT_CTRL    2'h1
`define MFA_FMT_IMM     2'h2
`define MFA_OP_SUB      4'h0
`define MFA_OP_ADD      4'h1
`define MFA_OP_SUBDEC   4'h2
`define MFA_OP_ADDINC   4'h3
`define MFA_OP_MUL      4'hE
`define MFA_OP_DIV      4'hF
`define MFA_OP_FCMP     4'h0
`define MFA_REG_DEST_PTR 5'h1E
`define MFA_REG_SRC_PTR  5'h1F
`define MFA_FLT_MODULE  4'h3
// Timing: figures in ns, cycle counts derived from the clock period
`define MFA_CLK_NS      50
`define MFA_T_BASIC_NS  240
`define MFA_T_FALL_NS   380
`define MFA_T_MUL_NS    2580
`define MFA_T_DIV_NS    4560
`define MFA_CYC(t)      (((t) + `MFA_CLK_NS - 1) / `MFA_CLK_NS)
`endif

// ==== mfa_pkg.sv ====
// Types of the fixed-point arithmetic unit
package mfa_pkg;
   typedef enum logic [0:0] {
      MFA_IDLE = 1'b0,
      MFA_EXEC = 1'b1
   } mfa_phase_type;
   typedef struct packed {
      mfa_phase_type    phase;
      logic [6:0]       cnt;
      logic [31:0]      instr;
      logic [3:0]       flags;
      logic [15:0]      loc;
      logic [3:0]       modSel;
      logic [7:0]       uptr;
      logic [4:0]       regIdx;
      logic [15:0][31:0] gpr;
      logic [15:0][31:0] fpr;
      logic             awHeld;
      logic [7:0]       awAddr;
      logic             wHeld;
      logic [31:0]      wData;
      logic [3:0]       wStrb;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } mfa_regs_type;
endpackage

// ==== mfa_seq_model.sv ====
// Bus master standing in for the micro-sequencer
`timescale 1ns/1ns
module mfa_seq_model (
   input  wire logic        core_clk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   // Idle bus; answers are always accepted at once
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
      bready = 1'h1;
      rready = 1'h1;
   end
   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'h0;
      w = 1'h0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(aw && w)) begin
         @(posedge core_clk);
         aw = aw | awready;
         w = w | wready;
         // Released lines show garbage so a stale value never passes
         if (aw) begin
            awvalid <= 1'h0;
            awaddr <= ~a;
         end
         if (w) begin
            wvalid <= 1'h0;
            wdata <= ~d;
         end
      end
      do @(posedge core_clk); while (!bvalid);
      r = bresp;
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'h0;
      araddr <= ~a;
      do @(posedge core_clk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
endmodule

// ==== mfa_arith_unit_asserts.sv ====
// Bus-level checker for the arithmetic unit
`timescale 1ns/1ns
module mfa_arith_unit_asserts (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wr_answer_a: assert property (awvalid && awready && wvalid && wready
      |=> !awready && !wready ##1 bvalid) else $error("write answer late");
   wr_release_a: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
   rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   rd_release_a: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read not released");
   bad_read_a: assert property (arvalid && arready && araddr == 8'h1C
      |=> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read");
   bad_write_a: assert property (awvalid && awready && wvalid && wready && awaddr == 8'h1C
      |=> ##1 bresp == 2'h2) else $error("unmapped write");
   status_pad_a: assert property (arvalid && arready && araddr == 8'h04
      |=> rdata[31:5] == 27'h0 && rresp == 2'h0) else $error("status padding");
   loc_width_a: assert property (arvalid && arready && araddr == 8'h08
      |=> rdata[31:16] == 16'h0) else $error("location width");
endmodule
bind mfa_arith_unit mfa_arith_unit_asserts u_chk (.*);

// ==== tb_micro_fixed_point_arith_unit.sv ====
// Self-checking bench for the fixed-point arithmetic unit
`timescale 1ns/1ns
module tb_micro_fixed_point_arith_unit;
   logic        core_clk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rr;
   int          miscompares, n_checks;
   mfa_arith_unit u_dut (.*);
   mfa_seq_model u_seq (.*);
   // 20 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      u_seq.wr(a, d, rr);
      chk("bresp", 32'h0, {30'h0, rr});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      u_seq.rd(a, rv, rr);
      chk("reg", e, rv);
   endtask
   task automatic set(input logic [4:0] i, input logic [31:0] v);
      wreg(8'h10, {27'h0, i});
      wreg(8'h14, v);
   endtask
   task automatic get(input logic [4:0] i, input logic [31:0] e);
      wreg(8'h10, {27'h0, i});
      rchk(8'h14, e);
   endtask
   task automatic flg(input logic [3:0] e);
      u_seq.rd(8'h04, rv, rr);
      chk("flags", {28'h0, e}, {28'h0, rv[3:0]});
   endtask
   // Micro-instruction word; cp is the C bit and page, or the low data bits
   function automatic logic [31:0] uins(logic [1:0] f, logic [4:0] s, logic [4:0] a,
                                        logic [3:0] op, logic [4:0] b, logic [6:0] cp);
      return {3'h1, f, 1'h0, s, a, op, b, cp};
   endfunction
   // Issue, then see busy just before n cycles and idle just after
   task automatic run(input logic [31:0] ins, input int n);
      wreg(8'h00, ins);
      repeat (n - 4) @(posedge core_clk);
      u_seq.rd(8'h04, rv, rr);
      chk("busy", 32'h1, {31'h0, rv[4]});
      repeat (3) @(posedge core_clk);
      u_seq.rd(8'h04, rv, rr);
      chk("idle", 32'h0, {31'h0, rv[4]});
   endtask
   task automatic t_bus();
      rchk(8'h08, 32'h0);
      rchk(8'h04, 32'h0);
      u_seq.rd(8'h1C, rv, rr);
      chk("rresp", 32'h2, {30'h0, rr});
      u_seq.wr(8'h1C, 32'h1, rr);
      chk("bresp", 32'h2, {30'h0, rr});
   endtask
   task automatic t_add();
      set(5'h01, 32'h7FFFFFFF);
      set(5'h02, 32'h00000001);
      run(uins(2'h1, 5'h03, 5'h01, 4'h1, 5'h02, 7'h00), 5);
      get(5'h03, 32'h80000000);
      flg(4'h5);
      set(5'h02, 32'h80000001);
      run(uins(2'h1, 5'h03, 5'h01, 4'h1, 5'h02, 7'h00), 5);
      get(5'h03, 32'h00000000);
      flg(4'h8);
   endtask
   task automatic t_inc();
      set(5'h01, 32'hFFFFFFFF);
      set(5'h02, 32'h00000000);
      wreg(8'h08, 32'h5FFF);
      run(uins(2'h0, 5'h03, 5'h01, 4'h3, 5'h02, 7'h6A), 8);
      get(5'h03, 32'h0);
      rchk(8'h08, 32'h5000);
      run(uins(2'h0, 5'h03, 5'h01, 4'h3, 5'h02, 7'h2A), 5);
      rchk(8'h08, 32'h502A);
   endtask
   task automatic t_sub();
      set(5'h01, 32'h0);
      set(5'h02, 32'h1);
      wreg(8'h08, 32'h0);
      run(uins(2'h0, 5'h03, 5'h01, 4'h0, 5'h02, 7'h55), 8);
      get(5'h03, 32'hFFFFFFFF);
      flg(4'h9);
      rchk(8'h08, 32'h1);
      set(5'h01, 32'h5);
      run(uins(2'h2, 5'h03, 5'h01, 4'h0, 5'h00, 7'h03), 5);
      get(5'h03, 32'h2);
      flg(4'h2);
      set(5'h01, 32'h80000000);
      run(uins(2'h1, 5'h03, 5'h01, 4'h2, 5'h02, 7'h00), 5);
      get(5'h03, 32'h7FFFFFFE);
      flg(4'h6);
   endtask
   // Clock enable low must freeze a running operation's count
   task automatic t_hold();
      wreg(8'h00, uins(2'h1, 5'h07, 5'h01, 4'h1, 5'h02, 7'h00));
      ce <= 1'h0;
      repeat (20) @(posedge core_clk);
      ce <= 1'h1;
      u_seq.rd(8'h04, rv, rr);
      chk("held busy", 32'h1, {31'h0, rv[4]});
      repeat (3) @(posedge core_clk);
      get(5'h07, 32'h80000001);
   endtask
   task automatic t_muldiv();
      wreg(8'h04, 32'hF);
      set(5'h05, 32'hFFFFFFFD);
      set(5'h06, 32'h7);
      wreg(8'h08, 32'h0);
      run(uins(2'h0, 5'h04, 5'h05, 4'hE, 5'h06, 7'h7F), 52);
      get(5'h04, 32'hFFFFFFFF);
      get(5'h05, 32'hFFFFFFEB);
      flg(4'h0);
      rchk(8'h08, 32'h3F);
      run(uins(2'h2, 5'h04, 5'h05, 4'hF, 5'h00, 7'h04), 92);
      get(5'h05, 32'hFFFFFFFB);
      get(5'h04, 32'hFFFFFFFF);
      set(5'h04, 32'h1);
      set(5'h05, 32'h12345678);
      set(5'h06, 32'h1);
      run(uins(2'h1, 5'h04, 5'h05, 4'hF, 5'h06, 7'h00), 92);
      flg(4'h4);
      get(5'h05, 32'h12345678);
   endtask
   task automatic fcmp(input logic [4:0] a, input logic [4:0] b, input logic [3:0] e);
      run(uins(2'h1, 5'h00, a, 4'h0, b, 7'h00) | 32'h40000000, 5);
      flg(e);
   endtask
   task automatic t_flt();
      wreg(8'h0C, 32'h3);
      set(5'h11, 32'h41100000);
      set(5'h12, 32'hC1100000);
      set(5'h13, 32'h42100000);
      fcmp(5'h01, 5'h02, 4'h2);
      fcmp(5'h02, 5'h01, 4'h9);
      fcmp(5'h01, 5'h03, 4'h9);
      fcmp(5'h03, 5'h03, 4'h0);
      get(5'h10, 32'h0);
      wreg(8'h18, 32'h21);
      run(uins(2'h1, 5'h1E, 5'h1F, 4'h1, 5'h1F, 7'h00), 5);
      get(5'h11, 32'h82200000);
      get(5'h01, 32'h80000000);
      set(5'h1F, 32'hA5A55A5A);
      get(5'h1F, 32'hA5A55A5A);
      wreg(8'h0C, 32'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      report_and_stop();
   end
   // Reset, then the scenarios in turn
   initial begin
      rst_n = 1'h0;
      ce = 1'h1;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      t_bus();
      t_add();
      t_inc();
      t_sub();
      t_hold();
      t_muldiv();
      t_flt();
      report_and_stop();
   end
endmodule
